// file: verilog/aoce_map.vh
`ifndef AOCE_MAP_VH
`define AOCE_MAP_VH

// ----------------------------------------
// Register byte offsets (APB, 32-bit words)
// ----------------------------------------
`define AOCE_MODES_OFF 12'h000
`define AOCE_OSC_OFF 12'h004
`define AOCE_STATUS_OFF 12'h008
`define AOCE_DATA_OFF 12'h00c

// ----------------------------------------
// Mode register fields
// ----------------------------------------
`define AOCE_F_HOST_CLK 0
`define AOCE_F_DDR 1
`define AOCE_F_LANES_LO 2
`define AOCE_F_LANES_HI 3
`define AOCE_F_WORD32 4
`define AOCE_MODES_RST 5'h00
`define AOCE_OSC_RST 8'h00

// ----------------------------------------
// Lane selections
// ----------------------------------------
`define AOCE_LANES_1 2'h0
`define AOCE_LANES_2 2'h1
`define AOCE_LANES_4 2'h2

// ----------------------------------------
// Word sizes and echo delay
// ----------------------------------------
`define AOCE_WORD_SHORT 6'h18
`define AOCE_WORD_LONG 6'h20
`define AOCE_ECHO_DELAY_NS 5.6
`define AOCE_CLK_NS 25
`define AOCE_ECHO_DELAY_CYC 1
`define AOCE_FIFO_WIDTH 32
`define AOCE_FIFO_DEPTH 16

`endif

// file: verilog/aoce_fifo.v
`timescale 1ns/10ps
`default_nettype none

module aoce_fifo #(
    parameter WIDTH = 32,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // Fill side
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    // Drain side
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);

    // Storage array and pointers, one extra bit tells full from empty
    reg [WIDTH-1:0] mem_q [0:DEPTH-1];
    reg [AW:0] wr_q;
    reg [AW:0] rd_q;

    wire full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
    wire empty = (wr_q == rd_q);
    wire push = in_valid && !full;
    wire pop = out_valid && out_ready;

    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem_q[rd_q[AW-1:0]];

    // Storage writes, no reset needed on data
    always @(posedge pclk) begin
        if (push) begin
            mem_q[wr_q[AW-1:0]] <= in_data;
        end
    end

    // Pointer update
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_q <= {(AW+1){1'b0}};
            rd_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end

endmodule // aoce_fifo

`default_nettype wire

// file: verilog/aoce_top.v
// Summary of operation
// R1: Echo mode returns delayed copy of host clock
// R2: Single rate: lanes change on rising edges
// R3: Double rate: lanes change on both edges
// R4: Same edge alignment for 1, 2, 4 lanes
// R5: Same edge relations for 24/32-bit words
// R6: Host clock single rate: rising edge per bit
// R7: Host clock double rate: both edges per bit
// R8: Host clock frequency set by oscillator divider
// R9: Host captures lanes on returned clock
//
// The APB slave port and the register offsets were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "aoce_map.vh"

module aoce_top (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Host serial port, sampled as synchronous inputs
    input wire cs_n,
    input wire sclk_in,
    // Returned clock and data lanes
    output reg returned_output_clock,
    output reg [3:0] serial_output_lanes
);

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    reg [4:0] modes_q; // Clock mode, rate, lanes, word size
    reg [7:0] oscillator_divider_q; // Half period of generated clock, minus one
    reg [7:0] osc_cnt_q; // Divider counter
    reg gen_clk_q; // Internally generated clock
    reg [31:0] shift_q; // Sample word being shifted out
    reg [5:0] bits_left_q; // Bits still to send
    reg loaded_q; // A word is in the shifter
    reg sclk_d1_q; // Host clock, one cycle delayed (echo delay)
    reg [3:0] frames_q; // Frames completed, wraps
    reg wr_pend_q; // Push request to FIFO
    reg [31:0] wr_data_q; // Word to push

    wire host_mode = modes_q[`AOCE_F_HOST_CLK];
    wire ddr = modes_q[`AOCE_F_DDR];
    wire [1:0] lanes = modes_q[`AOCE_F_LANES_HI:`AOCE_F_LANES_LO];
    wire [5:0] word_bits = modes_q[`AOCE_F_WORD32] ? `AOCE_WORD_LONG : `AOCE_WORD_SHORT;

    // FIFO wiring
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [31:0] fifo_out_data;
    wire fifo_pop;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Number of bits moved per data edge for a lane setting
    function [5:0] lane_step;
        input [1:0] sel;
        begin
            case (sel)
                `AOCE_LANES_2: lane_step = 6'h02;
                `AOCE_LANES_4: lane_step = 6'h04;
                default: lane_step = 6'h01;
            endcase
        end
    endfunction

    // Next lane levels taken from the top of the shifter
    function [3:0] lane_bits;
        input [1:0] sel;
        input [31:0] word;
        begin
            case (sel)
                `AOCE_LANES_2: lane_bits = {2'h0, word[31:30]};
                `AOCE_LANES_4: lane_bits = word[31:28];
                default: lane_bits = {3'h0, word[31]};
            endcase
        end
    endfunction

    // ----------------------------------------
    // APB slave, zero wait states
    // ----------------------------------------
    wire apb_acc = psel && penable;
    wire apb_wr = apb_acc && pwrite;

    // Register writes and read data; data writes queue a word for the FIFO
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            modes_q <= `AOCE_MODES_RST;
            oscillator_divider_q <= `AOCE_OSC_RST;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            wr_pend_q <= 1'b0;
            wr_data_q <= 32'h0000_0000;
        end else begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            if (wr_pend_q && fifo_in_ready) begin
                wr_pend_q <= 1'b0;
            end
            if (psel && !penable) begin
                // Setup phase: decode and prepare answer
                case (paddr)
                    `AOCE_MODES_OFF: prdata <= {27'h0, modes_q};
                    `AOCE_OSC_OFF: prdata <= {24'h0, oscillator_divider_q};
                    `AOCE_STATUS_OFF: prdata <= {22'h0, frames_q, loaded_q,
                                                 fifo_out_valid, !fifo_in_ready,
                                                 wr_pend_q, 2'h0};
                    `AOCE_DATA_OFF: prdata <= 32'h0000_0000;
                    default: begin
                        prdata <= 32'h0000_0000;
                        pslverr <= 1'b1; // Unmapped address
                    end
                endcase
            end
            if (apb_wr && pready) begin
                case (paddr)
                    `AOCE_MODES_OFF: modes_q <= pwdata[4:0];
                    `AOCE_OSC_OFF: oscillator_divider_q <= pwdata[7:0];
                    `AOCE_DATA_OFF: begin
                        // A word still pending drops the new word; status shows pending first
                        if (!wr_pend_q) begin
                            wr_pend_q <= 1'b1;
                            wr_data_q <= pwdata;
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    // ----------------------------------------
    // Word FIFO between bus and shifter
    // ----------------------------------------
    aoce_fifo #(
        .WIDTH(`AOCE_FIFO_WIDTH),
        .DEPTH(`AOCE_FIFO_DEPTH),
        .AW(4)
    ) u_fifo (
        .pclk(pclk),
        .presetn(presetn),
        .in_valid(wr_pend_q),
        .in_ready(fifo_in_ready),
        .in_data(wr_data_q),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out_data)
    );

    // ----------------------------------------
    // Clock source: echo or divided oscillator
    // ----------------------------------------
    // Generated clock toggles every divider+1 cycles while framed
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_cnt_q <= 8'h00;
            gen_clk_q <= 1'b0;
            sclk_d1_q <= 1'b0;
        end else begin
            sclk_d1_q <= sclk_in; // One cycle covers the echo delay
            // Runs for the whole frame so its half period never shortens at a word end
            if (cs_n || !host_mode) begin
                osc_cnt_q <= 8'h00;
                gen_clk_q <= 1'b0;
            end else if (osc_cnt_q == oscillator_divider_q) begin // [R8]
                osc_cnt_q <= 8'h00;
                gen_clk_q <= !gen_clk_q;
            end else begin
                osc_cnt_q <= osc_cnt_q + 8'h01;
            end
        end
    end

    // Selected clock and its edges
    wire src_clk = host_mode ? gen_clk_q : sclk_d1_q;
    wire src_rise = src_clk && !returned_output_clock;
    wire src_fall = !src_clk && returned_output_clock;
    // Data edges: rising only, or both in double rate
    wire data_edge = src_rise || (ddr && src_fall); // [R2] [R3] [R6] [R7]
    assign fifo_pop = !loaded_q && fifo_out_valid && !cs_n;

    // ----------------------------------------
    // Output clock and lane shifter
    // ----------------------------------------
    // Lanes update in the same cycle as the returned clock edge
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            returned_output_clock <= 1'b0;
            serial_output_lanes <= 4'h0;
            shift_q <= 32'h0000_0000;
            bits_left_q <= 6'h00;
            loaded_q <= 1'b0;
            frames_q <= 4'h0;
        end else begin
            returned_output_clock <= src_clk; // [R1]
            if (cs_n) begin
                loaded_q <= 1'b0;
                bits_left_q <= 6'h00;
                serial_output_lanes <= 4'h0; // Idle lanes low, none left over
            end else if (fifo_pop) begin
                // Left-justify short words so the top bit leads [R5]
                shift_q <= modes_q[`AOCE_F_WORD32] ? fifo_out_data
                                                   : {fifo_out_data[23:0], 8'h00};
                bits_left_q <= word_bits;
                loaded_q <= 1'b1;
            end else if (loaded_q && data_edge) begin
                // Same edge rule for every lane count [R4]
                serial_output_lanes <= lane_bits(lanes, shift_q);
                shift_q <= shift_q << lane_step(lanes);
                if (bits_left_q <= lane_step(lanes)) begin
                    bits_left_q <= 6'h00;
                    loaded_q <= 1'b0;
                    frames_q <= frames_q + 4'h1;
                end else begin
                    bits_left_q <= bits_left_q - lane_step(lanes);
                end
            end
        end
    end

endmodule // aoce_top

`default_nettype wire

// file: verif/aoce_chk.sv
`timescale 1ns/10ps
`default_nettype none
`include "aoce_map.vh"
module aoce_chk (
    // Bus and clock
    input wire logic pclk, presetn, psel, penable, pwrite, pready, pslverr,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata, prdata,
    // Serial side
    input wire logic cs_n, sclk_in, returned_output_clock,
    input wire logic [3:0] serial_output_lanes
);
    // ----------------
    // Shadow state
    // ----------------
    logic [4:0] md_q; // Mode copy
    logic [7:0] dv_q; // Divider copy
    logic [9:0] cnt_q; // Cycles since clock edge
    logic seen_q; // Edge seen in frame
    logic rc_q; // Last clock level
    wire logic wr = psel && penable && pready && pwrite;
    wire logic tg = returned_output_clock ^ rc_q;
    // Mirror bus writes; first edge of a frame has no reference
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            md_q <= 5'h00;
            dv_q <= 8'h00;
            cnt_q <= 10'h000;
            seen_q <= 1'b0;
            rc_q <= 1'b0;
        end else begin
            rc_q <= returned_output_clock;
            if (wr && paddr == `AOCE_MODES_OFF) md_q <= pwdata[4:0];
            if (wr && paddr == `AOCE_OSC_OFF) dv_q <= pwdata[7:0];
            cnt_q <= tg ? 10'h001 : cnt_q + 10'h001;
            seen_q <= !cs_n && (seen_q || tg);
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_steady;
        !cs_n [*3];
    endsequence
    AST_ECHO_COPY: assert property (s_steady ##0 !md_q[0] |->
        returned_output_clock == $past(sclk_in, 2)) else $error("echo clock wrong");
    AST_ECHO_SDR: assert property (s_steady ##0 (md_q[1:0] == 2'b00 &&
        $changed(serial_output_lanes)) |-> $rose(returned_output_clock)) else $error("sdr edge");
    AST_ECHO_DDR: assert property (s_steady ##0 (md_q[1:0] == 2'b10 &&
        $changed(serial_output_lanes)) |-> $changed(returned_output_clock)) else $error("ddr edge");
    AST_ONE_LANE: assert property (s_steady ##0 md_q[3:2] == `AOCE_LANES_1 |->
        serial_output_lanes[3:1] == 3'h0) else $error("unused lane moved");
    AST_LONG_WORD: assert property (s_steady ##0 (md_q[4] && !md_q[1] &&
        $changed(serial_output_lanes)) |-> $rose(returned_output_clock)) else $error("long edge");
    AST_HOST_SDR: assert property (s_steady ##0 (md_q[1:0] == 2'b01 &&
        $changed(serial_output_lanes)) |-> $rose(returned_output_clock)) else $error("host sdr");
    AST_HOST_DDR: assert property (s_steady ##0 (md_q[1:0] == 2'b11 &&
        $changed(serial_output_lanes)) |-> $changed(returned_output_clock)) else $error("host ddr");
    AST_HOST_DIV: assert property (s_steady ##0 (md_q[0] && seen_q && tg) |->
        cnt_q == {2'h0, dv_q} + 10'h001) else $error("host half period");
endmodule // aoce_chk
bind aoce_top aoce_chk aoce_chk_inst (.pclk, .presetn, .psel, .penable, .pwrite, .pready,
    .pslverr, .paddr, .pwdata, .prdata, .cs_n, .sclk_in, .returned_output_clock,
    .serial_output_lanes);
`default_nettype wire

// file: verif/aoce_host.sv
`timescale 1ns/10ps
`default_nettype none
module aoce_host (
    // Returned side
    input wire logic pclk, presetn, returned_output_clock,
    input wire logic [3:0] serial_output_lanes,
    // Host drive
    output logic cs_n, sclk_in
);
    logic [31:0] cap_q; // Captured word
    logic rc_q; // Last clock level
    logic ddr; // Both edges carry data
    int n_q = 0, tgt = 0, nl = 1;
    initial begin
        cs_n = 1'b1;
        sclk_in = 1'b0;
    end
    // Capture on returned clock, never on own clock
    always @(posedge pclk) begin
        rc_q <= returned_output_clock;
        if (n_q < tgt && returned_output_clock !== rc_q && (ddr || returned_output_clock)) begin
            cap_q <= (cap_q << nl) | 32'(serial_output_lanes & 4'((1 << nl) - 1));
            n_q <= n_q + nl;
        end
    end
    // One frame; clock stands still outside it
    task automatic frame(input int w, ln, input logic d, h, input int half);
        int k;
        k = 0;
        tgt = w;
        nl = ln;
        ddr = d;
        @(posedge pclk);
        cs_n <= 1'b0;
        n_q <= 0;
        cap_q <= 32'h0;
        repeat (4) @(posedge pclk);
        while (n_q < tgt && k < 3000) begin
            if (!h) begin
                repeat (half - 1) @(posedge pclk);
                sclk_in <= !sclk_in;
            end
            @(posedge pclk);
            k++;
        end
        cs_n <= 1'b1;
        @(posedge pclk);
        sclk_in <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask
endmodule // aoce_host
`default_nettype wire

// file: verif/tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "aoce_map.vh"
module tb;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic pready, pslverr, cs_n, sclk_in, returned_output_clock, e;
    logic [3:0] serial_output_lanes;
    int bad_count = 0, n_tests = 0;
    always #12.5 pclk = ~pclk;
    aoce_top aoce_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .cs_n, .sclk_in, .returned_output_clock,
        .serial_output_lanes);
    aoce_host aoce_host_inst (.pclk, .presetn, .returned_output_clock,
        .serial_output_lanes, .cs_n, .sclk_in);
    // ----------------
    // Helpers
    // ----------------
    task automatic chk(input string s, input logic [31:0] x, g);
        n_tests++;
        if (g !== x) begin
            $display("Error %s expected %h seen %h", s, x, g);
            bad_count++;
        end
    endtask
    // Held until pready is seen; only the watchdog ends a wait
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic t_regs;
        apb(1'b1, `AOCE_OSC_OFF, 32'h5a);
        apb(1'b0, `AOCE_OSC_OFF, 32'h0);
        chk("divider", 32'h5a, r);
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped", 32'h1, {31'h0, e});
    endtask
    // Every lane count, both rates, both word sizes
    task automatic t_echo;
        logic [31:0] w;
        for (int i = 0; i < 12; i++) begin
            w = 32'hc5a3_96e1 + i;
            apb(1'b1, `AOCE_MODES_OFF, {27'h0, i >= 6, 2'(i % 3), 1'((i / 3) % 2), 1'b0});
            apb(1'b1, `AOCE_DATA_OFF, w);
            aoce_host_inst.frame(i >= 6 ? 32 : 24, 1 << (i % 3), 1'((i / 3) % 2), 1'b0, 4);
            chk("echo", i >= 6 ? w : {8'h0, w[23:0]}, aoce_host_inst.cap_q);
        end
        apb(1'b0, `AOCE_MODES_OFF, 32'h0);
        chk("modes", 32'h1a, r);
        apb(1'b0, `AOCE_STATUS_OFF, 32'h0);
        chk("frames", 32'hc, {28'h0, r[9:6]});
    endtask
    task automatic t_host;
        apb(1'b1, `AOCE_OSC_OFF, 32'h2);
        for (int d = 0; d < 2; d++) begin
            apb(1'b1, `AOCE_MODES_OFF, {30'h0, 1'(d), 1'b1});
            apb(1'b1, `AOCE_DATA_OFF, 32'h0036_c9a5);
            aoce_host_inst.frame(24, 1, 1'(d), 1'b1, 0);
            chk("host", 32'h0036_c9a5, aoce_host_inst.cap_q);
        end
    endtask
    // Fill past full, then drain while the host paces frames
    task automatic t_fifo;
        apb(1'b1, `AOCE_MODES_OFF, 32'h8);
        for (int i = 0; i < 17; i++) apb(1'b1, `AOCE_DATA_OFF, 32'h00a0_0000 + i);
        apb(1'b0, `AOCE_STATUS_OFF, 32'h0);
        chk("fifo flags", 32'h3, {30'h0, r[4:3]});
        for (int k = 0; k < 20 && r[4]; k++) begin
            aoce_host_inst.frame(24, 4, 1'b0, 1'b0, 4);
            apb(1'b0, `AOCE_STATUS_OFF, 32'h0);
        end
        chk("drained", 32'h0, {31'h0, r[4]});
        // The pending 17th word is kept, and each frame end loads and drops one more word
        chk("last word", 32'h00a0_0010, aoce_host_inst.cap_q);
    endtask
    task automatic close_out;
        if (bad_count == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge pclk);
        bad_count++;
        close_out;
    end
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_regs;
        t_echo;
        t_host;
        t_fifo;
        close_out;
    end
endmodule // tb
`default_nettype wire
